// >>> backplane_cards.sv
// Behavioural memory and input-port cards on the backplane.
// Assumes registered status and strobe outputs from the sequencer.
`default_nettype none
module backplane_cards
(
    input  wire logic        sys_clk_i,
    input  wire logic [15:0] address_i,
    input  wire logic        memory_read_i,
    input  wire logic        port_input_i,
    input  wire logic        data_in_strobe_i,
    output logic      [7:0]  data_in_lines_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] held = 8'h00;
    // Released lines show the inverse of the last byte, so a late sample is caught
    always_comb
        if (data_in_strobe_i && memory_read_i)
            data_in_lines_o = address_i[7:0] ^ address_i[15:8] ^ 8'hA5;
        else if (data_in_strobe_i && port_input_i)
            data_in_lines_o = address_i[7:0] + 8'h33;
        else
            data_in_lines_o = ~held;
    always @(posedge sys_clk_i)
        if (data_in_strobe_i)
            held <= data_in_lines_o;
endmodule
`default_nettype wire

// >>> bus_read_cycle_asserts.sv
// Checker for the read-cycle sequencer, bound to its ports.
// Assumes one clock domain and the async active-low reset.
`default_nettype none
module bus_read_cycle_asserts
(
    input wire logic        sys_clk_i,
    input wire logic        arst_n_i,
    input wire logic [15:0] address_lines_o,
    input wire logic [7:0]  status_data_o,
    input wire logic        bus_cycle_sync_o,
    input wire logic        status_latch_strobe_n_o,
    input wire logic        status_memory_read_o,
    input wire logic        status_port_input_o,
    input wire logic        status_opcode_fetch_o,
    input wire logic        cpu_data_in_enable_o,
    input wire logic        bus_data_in_strobe_o,
    input wire logic        buffer_input_enable_n_o,
    input wire logic [15:0] program_counter_o,
    input wire logic        busy_o,
    input wire logic        done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    // One state per clock: T2 is the strobe alone, T3 the enable alone
    sequence t2_s; !status_latch_strobe_n_o && !bus_cycle_sync_o; endsequence
    sequence t3_s; cpu_data_in_enable_o && status_latch_strobe_n_o; endsequence
    a_three_states: assert property (bus_cycle_sync_o |=> t2_s ##1 t3_s ##1 (bus_cycle_sync_o || done_o))
        else $error("read cycle not T1 T2 T3");
    a_sync_busy: assert property (bus_cycle_sync_o |-> busy_o && status_latch_strobe_n_o)
        else $error("sync outside a busy T1");
    a_strobe_cause: assert property (!status_latch_strobe_n_o |-> $past(bus_cycle_sync_o))
        else $error("strobe without prior sync");
    a_latch_load: assert property (!status_latch_strobe_n_o |=> {status_memory_read_o, status_port_input_o,
        status_opcode_fetch_o} == $past(status_data_o[7:5]))
        else $error("latch missed status byte");
    a_latch_hold: assert property (status_latch_strobe_n_o |=> $stable({status_memory_read_o,
        status_port_input_o, status_opcode_fetch_o}))
        else $error("latch changed without strobe");
    a_enable_copy: assert property (bus_data_in_strobe_o == cpu_data_in_enable_o
        && buffer_input_enable_n_o == !cpu_data_in_enable_o)
        else $error("bus strobe differs from enable");
    a_port_mirror: assert property (bus_cycle_sync_o && status_data_o[6] |->
        address_lines_o[15:8] == address_lines_o[7:0])
        else $error("port number not on both bytes");
    a_pc_hold: assert property (bus_cycle_sync_o && status_data_o[6] |-> $stable(program_counter_o)[*3])
        else $error("counter moved in input cycle");
endmodule
bind bus_read_cycle_sequencer bus_read_cycle_asserts u_chk (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .address_lines_o(address_lines_o), .status_data_o(status_data_o), .bus_cycle_sync_o(bus_cycle_sync_o),
    .status_latch_strobe_n_o(status_latch_strobe_n_o), .status_memory_read_o(status_memory_read_o),
    .status_port_input_o(status_port_input_o), .status_opcode_fetch_o(status_opcode_fetch_o),
    .cpu_data_in_enable_o(cpu_data_in_enable_o), .bus_data_in_strobe_o(bus_data_in_strobe_o),
    .buffer_input_enable_n_o(buffer_input_enable_n_o), .program_counter_o(program_counter_o),
    .busy_o(busy_o), .done_o(done_o));
`default_nettype wire

// >>> bus_read_cycle_defs.vh
// Constants for the backplane read-cycle sequencer.
// Assumes inclusion by bare name from the sequencer sources.
`ifndef BUS_READ_CYCLE_DEFS_VH
`define BUS_READ_CYCLE_DEFS_VH

// Opcode of the input instruction, octal 333
`define OPC_INPUT          8'hDB
// Status byte bit positions
`define ST_BIT_MEMR        7
`define ST_BIT_INP         6
`define ST_BIT_M1          5
// Status bytes driven in T1, and the byte loaded at reset
`define ST_BYTE_MEM_READ   8'h80
`define ST_BYTE_PORT_INPUT 8'h40
`define ST_BYTE_RESET      8'h00
// Machine-cycle kinds
`define CYC_OPERAND_LOW    2'h0
`define CYC_OPERAND_HIGH   2'h1
`define CYC_PORT_NUMBER    2'h2
`define CYC_PORT_INPUT     2'h3
// Clock states per read cycle
`define STATES_PER_CYCLE   2'h3
`define PC_RESET           16'h0000

`endif

// >>> bus_read_cycle_sequencer.v
// Sequencer for operand memory reads and the input read cycle on the backplane.
// Assumes start_i pulses after an opcode fetch; backplane inputs are synchronous.
`include "bus_read_cycle_defs.vh"
`default_nettype none

module bus_read_cycle_sequencer
(
    input  wire        sys_clk_i,
    input  wire        arst_n_i,
    input  wire        clk_en_i,
    input  wire        start_i,
    input  wire [7:0]  opcode_i,
    input  wire        port_access_i,
    input  wire [15:0] pc_fetch_i,
    input  wire [7:0]  data_in_lines_i,
    input  wire        front_panel_input_gate_i,
    output reg  [15:0] address_lines_o,
    output reg  [7:0]  status_data_o,
    output reg         bus_cycle_sync_o,
    output wire        status_latch_strobe_n_o,
    output wire        status_memory_read_o,
    output wire        status_port_input_o,
    output wire        status_opcode_fetch_o,
    output reg         cpu_data_in_enable_o,
    output wire        bus_data_in_strobe_o,
    output wire        buffer_input_enable_n_o,
    output reg  [15:0] operand_address_o,
    output reg  [7:0]  port_data_o,
    output reg  [15:0] program_counter_o,
    output wire        busy_o,
    output reg         done_o
);

    // Clock states; binary codes
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_T1   = 2'h1;
    localparam [1:0] ST_T2   = 2'h2;
    localparam [1:0] ST_T3   = 2'h3;

    reg  [1:0] tstate;
    reg  [1:0] next_tstate;
    reg  [1:0] cycle_kind;
    reg        strobe_pending;
    wire [7:0] latched_status;
    wire       gated_in;

    assign busy_o = (tstate != ST_IDLE);

    // One-clock low strobe right at the start of T2, following a high sync
    assign status_latch_strobe_n_o = ~strobe_pending;

    status_latch u_status_latch
    (
        .sys_clk_i  (sys_clk_i),
        .arst_n_i   (arst_n_i),
        .clk_en_i   (clk_en_i),
        .strobe_n_i (status_latch_strobe_n_o),
        .status_i   (status_data_o),
        .status_o   (latched_status)
    );

    // Backplane status lines come only from the latch, never from T1 data
    assign status_memory_read_o  = latched_status[`ST_BIT_MEMR];
    assign status_port_input_o   = latched_status[`ST_BIT_INP];
    assign status_opcode_fetch_o = latched_status[`ST_BIT_M1];

    // Data-in enable repeated to the bus; buffers open while it is high
    assign bus_data_in_strobe_o    = cpu_data_in_enable_o;
    assign buffer_input_enable_n_o = ~cpu_data_in_enable_o;
    // Front-panel gate low means the panel owns the data path
    assign gated_in = cpu_data_in_enable_o & front_panel_input_gate_i;

    // Three states per machine cycle, then either chain or go idle
    always @*
    begin
        next_tstate = tstate;
        case (tstate)
            ST_IDLE:
                if (start_i)
                    next_tstate = ST_T1;
            ST_T1:
                next_tstate = ST_T2;
            ST_T2:
                next_tstate = ST_T3;
            ST_T3:
                if (cycle_kind == `CYC_OPERAND_LOW && !port_access_i)
                    next_tstate = ST_T1;
                else if (cycle_kind == `CYC_PORT_NUMBER && opcode_i == `OPC_INPUT)
                    next_tstate = ST_T1;
                else
                    next_tstate = ST_IDLE;
            default:
                next_tstate = ST_IDLE;
        endcase
    end

    // Sequencing, bus drive and capture of inbound bytes
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            tstate               <= ST_IDLE;
            cycle_kind           <= `CYC_OPERAND_LOW;
            strobe_pending       <= 1'b0;
            address_lines_o      <= `PC_RESET;
            status_data_o        <= `ST_BYTE_RESET;
            bus_cycle_sync_o     <= 1'b0;
            cpu_data_in_enable_o <= 1'b0;
            operand_address_o    <= `PC_RESET;
            port_data_o          <= 8'h00;
            program_counter_o    <= `PC_RESET;
            done_o               <= 1'b0;
        end
        else if (clk_en_i)
        begin
            tstate         <= next_tstate;
            done_o         <= 1'b0;
            strobe_pending <= (tstate == ST_T1) && bus_cycle_sync_o;
            bus_cycle_sync_o <= 1'b0;
            case (tstate)
                ST_IDLE:
                    if (start_i)
                    begin
                        // Operand read starts at the incremented fetch address
                        program_counter_o <= pc_fetch_i + 16'h0001;
                        address_lines_o   <= pc_fetch_i + 16'h0001;
                        status_data_o     <= `ST_BYTE_MEM_READ;
                        bus_cycle_sync_o  <= 1'b1;
                        cycle_kind        <= port_access_i ? `CYC_PORT_NUMBER : `CYC_OPERAND_LOW;
                    end
                ST_T1:
                    // Enable raised at the end of T2 so it covers T3 only
                    cpu_data_in_enable_o <= 1'b0;
                ST_T2:
                    cpu_data_in_enable_o <= 1'b1;
                ST_T3:
                begin
                    cpu_data_in_enable_o <= 1'b0;
                    case (cycle_kind)
                        `CYC_OPERAND_LOW:
                        begin
                            if (gated_in)
                                operand_address_o[7:0] <= data_in_lines_i;
                            if (!port_access_i)
                            begin
                                program_counter_o <= program_counter_o + 16'h0001;
                                address_lines_o   <= program_counter_o + 16'h0001;
                                status_data_o     <= `ST_BYTE_MEM_READ;
                                bus_cycle_sync_o  <= 1'b1;
                                cycle_kind        <= `CYC_OPERAND_HIGH;
                            end
                            else
                                done_o <= 1'b1;
                        end
                        `CYC_OPERAND_HIGH:
                        begin
                            if (gated_in)
                                operand_address_o[15:8] <= data_in_lines_i;
                            program_counter_o <= program_counter_o + 16'h0001;
                            done_o <= 1'b1;
                        end
                        `CYC_PORT_NUMBER:
                        begin
                            if (gated_in)
                                operand_address_o <= {8'h00, data_in_lines_i};
                            if (opcode_i == `OPC_INPUT)
                            begin
                                // Device number on both halves; counter left as is
                                // With the panel gate low the held number is reused, not raw bus data
                                if (gated_in)
                                    address_lines_o <= {data_in_lines_i, data_in_lines_i};
                                else
                                    address_lines_o <= {operand_address_o[7:0], operand_address_o[7:0]};
                                status_data_o    <= `ST_BYTE_PORT_INPUT;
                                bus_cycle_sync_o <= 1'b1;
                                cycle_kind       <= `CYC_PORT_INPUT;
                            end
                            else
                            begin
                                program_counter_o <= program_counter_o + 16'h0001;
                                done_o <= 1'b1;
                            end
                        end
                        `CYC_PORT_INPUT:
                        begin
                            if (gated_in)
                                port_data_o <= data_in_lines_i;
                            program_counter_o <= program_counter_o + 16'h0001;
                            done_o <= 1'b1;
                        end
                        default:
                            done_o <= 1'b1;
                    endcase
                end
                default:
                    cpu_data_in_enable_o <= 1'b0;
            endcase
        end
    end

endmodule

`default_nettype wire

// >>> status_latch.v
// Eight-bit status latch loaded by the active-low status strobe.
// Assumes the strobe is a one-clock low pulse synchronous to sys_clk_i.
`include "bus_read_cycle_defs.vh"
`default_nettype none

module status_latch
(
    input  wire       sys_clk_i,
    input  wire       arst_n_i,
    input  wire       clk_en_i,
    input  wire       strobe_n_i,
    input  wire [7:0] status_i,
    output reg  [7:0] status_o
);

    // Holds between strobes so the backplane sees a steady status from T3 until the next T2
    always @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            status_o <= `ST_BYTE_RESET;
        else if (clk_en_i && !strobe_n_i)
            status_o <= status_i;
    end

endmodule

`default_nettype wire

// >>> tb.sv
// Self-checking bench for the read-cycle sequencer.
// Assumes the sequencer header is found by bare name.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk_i = 1'b0, arst_n_i = 1'b0, start = 1'b0, port = 1'b0, gate = 1'b1;
    logic [7:0]  opcode = 8'h00, din, sdata, pdata;
    logic [15:0] fpc = 16'h0000, addr, oper, pc;
    logic        sync, stb_n, memr, inp, den, bstb, busy, done;
    logic [15:0] seen_addr [$];
    logic [7:0]  seen_st [$];
    int          n_errors = 0, n_checks = 0, cycles = 0;
    always #50 sys_clk_i = ~sys_clk_i;
    // Clock enable is tied high: freezing is not exercised here
    bus_read_cycle_sequencer DUT (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1), .start_i(start),
        .opcode_i(opcode), .port_access_i(port), .pc_fetch_i(fpc), .data_in_lines_i(din),
        .front_panel_input_gate_i(gate), .address_lines_o(addr), .status_data_o(sdata), .bus_cycle_sync_o(sync),
        .status_latch_strobe_n_o(stb_n), .status_memory_read_o(memr), .status_port_input_o(inp),
        .status_opcode_fetch_o(), .cpu_data_in_enable_o(den), .bus_data_in_strobe_o(bstb),
        .buffer_input_enable_n_o(), .operand_address_o(oper), .port_data_o(pdata),
        .program_counter_o(pc), .busy_o(busy), .done_o(done));
    backplane_cards cards (.sys_clk_i(sys_clk_i), .address_i(addr), .memory_read_i(memr),
        .port_input_i(inp), .data_in_strobe_i(bstb), .data_in_lines_o(din));
    function automatic logic [7:0] mem(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Launch one instruction and log address and status at every T1
    task automatic run_op(input logic [7:0] op, input logic pa, input logic [15:0] f);
        int k;
        seen_addr.delete();
        seen_st.delete();
        @(posedge sys_clk_i);
        opcode <= op;
        port <= pa;
        fpc <= f;
        start <= 1'b1;
        @(posedge sys_clk_i);
        start <= 1'b0;
        for (k = 0; k < 20 && done !== 1'b1; k++)
        begin
            @(negedge sys_clk_i);
            if (sync === 1'b1)
            begin
                seen_addr.push_back(addr);
                seen_st.push_back(sdata);
            end
        end
    endtask
    // Counter page boundary: the carry must reach the high byte
    task automatic test_mem;
        run_op(8'h3A, 1'b0, 16'h12FE);
        check(16'(seen_addr.size()), 16'h0002);
        check(seen_addr[0], 16'h12FF);
        check(16'(seen_st[0]), 16'h0080);
        check(oper, {mem(16'h1300), mem(16'h12FF)});
        check(pc, 16'h1301);
        $display("test mem done");
    endtask
    task automatic test_gate;
        @(posedge sys_clk_i);
        gate <= 1'b0;
        run_op(8'h3A, 1'b0, 16'h0200);
        check(oper, {mem(16'h1300), mem(16'h12FF)});
        check(pc, 16'h0203);
        @(posedge sys_clk_i);
        gate <= 1'b1;
        $display("test gate done");
    endtask
    task automatic test_port_out;
        run_op(8'hD3, 1'b1, 16'h0300);
        check(16'(seen_addr.size()), 16'h0001);
        check(oper, {8'h00, mem(16'h0301)});
        check(pc, 16'h0302);
        $display("test port out done");
    endtask
    task automatic test_input;
        logic [7:0] n;
        logic [7:0] d;
        n = mem(16'h0411);
        d = n + 8'h33;
        run_op(8'hDB, 1'b1, 16'h0410);
        check(16'(seen_addr.size()), 16'h0002);
        check(16'(seen_st[1]), 16'h0040);
        check(seen_addr[1], {n, n});
        check(16'(pdata), 16'(d));
        check(pc, 16'h0412);
        $display("test input done");
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Whole run needs about 40 cycles, so 3000 means a hang
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (6) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        test_mem();
        test_gate();
        test_port_out();
        test_input();
        give_verdict();
    end
endmodule
`default_nettype wire
